// ### hdl/cja_pkg.sv
// Constants for the call/jump/add/and execution block.
// Assumes one machine cycle per clk and byte-wide memories.
package cja_pkg;
	// ======================================================
	// Opcodes and masks
	localparam logic [7:0] OP_ADD_REG   = 8'h28;
	localparam logic [7:0] OP_ADD_DIR   = 8'h25;
	localparam logic [7:0] OP_ADD_IND   = 8'h26;
	localparam logic [7:0] OP_ADD_IMM   = 8'h24;
	localparam logic [7:0] OP_ADD_WITH_CARRY_REG  = 8'h38;
	localparam logic [7:0] OP_ADD_WITH_CARRY_DIR  = 8'h35;
	localparam logic [7:0] OP_ADD_WITH_CARRY_IND  = 8'h36;
	localparam logic [7:0] OP_ADD_WITH_CARRY_IMM  = 8'h34;
	localparam logic [7:0] OP_AND_REG   = 8'h58;
	localparam logic [7:0] OP_AND_DIR   = 8'h55;
	localparam logic [7:0] OP_AND_IND   = 8'h56;
	localparam logic [7:0] OP_AND_IMM   = 8'h54;
	localparam logic [7:0] OP_AND_DIRA  = 8'h52;
	localparam logic [7:0] OP_AND_DIRI  = 8'h53;
	localparam logic [7:0] OP_ANDC_BIT  = 8'h82;
	localparam logic [7:0] OP_ANDC_NBIT = 8'hb0;
	localparam logic [4:0] OP_ABSOLUTE_CALL_LO  = 5'h11;
	localparam logic [4:0] OP_ABSOLUTE_JUMP_LO   = 5'h01;
	// ======================================================
	// Reset values and lowest port address
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0]  SP_RESET = 8'h07;
	localparam logic [7:0]  PORT_LO  = 8'h80;
	// ======================================================
	// Data-memory request kinds
	typedef enum logic [1:0] {
		MEM_RD_IDLE = 2'h0,
		MEM_RD_BYTE = 2'h1,
		MEM_RD_BIT  = 2'h2
	} cja_rd_type;
endpackage : cja_pkg

// ### hdl/cja_mem_if.sv
// Operand and flag bundle between decoder and adder.
// Assumes the adder answers combinationally.
`timescale 1ns/1ps
`default_nettype none
interface cja_alu_if;
	logic [7:0] a;
	logic [7:0] b;
	logic       cin;
	logic [7:0] sum;
	logic       cy;
	logic       ac;
	logic       ov;
	modport core (output a, b, cin, input sum, cy, ac, ov);
	modport alu  (input a, b, cin, output sum, cy, ac, ov);
endinterface : cja_alu_if
`default_nettype wire

// ### hdl/cja_adder.sv
// Byte adder with carry, auxiliary carry and overflow.
// Assumes the caller zeroes cin for plain addition.
`timescale 1ns/1ps
`default_nettype none
module cja_adder
	import cja_pkg::*;
(
	cja_alu_if.alu  bus
);
	logic [4:0] lo;
	logic [3:0] mid;
	logic [1:0] hi;
	// ======================================================
	// Split sum to expose carries out of bits 3, 6 and 7
	always_comb
	begin
		lo  = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
		mid = {1'b0, bus.a[6:4]} + {1'b0, bus.b[6:4]} + {3'h0, lo[4]};
		hi  = {1'b0, bus.a[7]} + {1'b0, bus.b[7]} + {1'b0, mid[3]};
		bus.sum = {hi[0], mid[2:0], lo[3:0]};
		bus.cy  = hi[1];
		bus.ac  = lo[4];
		bus.ov  = hi[1] ^ mid[3];
	end
endmodule : cja_adder
`default_nettype wire

// ### hdl/cja_core.sv
// Executes absolute call/jump, add, add-with-carry and AND forms.
// Assumes program and data memories answer combinationally.
`timescale 1ns/1ps
`default_nettype none
module cja_core
	import cja_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	output logic [15:0]      progAddr,
	input  wire logic [7:0]  progData,
	output logic [7:0]       dataRdAddr,
	input  wire logic [7:0]  dataRdByte,
	input  wire logic [7:0]  latchRdByte,
	output logic             bitRd,
	output logic [7:0]       dataWrAddr,
	output logic [7:0]       dataWrByte,
	output logic             dataWr,
	input  wire logic [7:0]  regFile [8],
	output logic [7:0]       acc,
	output logic             carry,
	output logic             auxiliary_carry_flag,
	output logic             overflow_flag,
	output logic [7:0]       stack_pointer,
	output logic [15:0]      program_counter,
	output logic             badOpcode
);
	typedef enum logic [4:0] {
		ST_FETCH = 5'b00001,
		ST_ARG1  = 5'b00010,
		ST_ARG2  = 5'b00100,
		ST_PUSH  = 5'b01000,
		ST_EXEC  = 5'b10000
	} cja_state_type;

	cja_state_type state;
	logic [7:0]    opcode;
	logic [7:0]    arg1;
	logic [15:0]   retAddr;
	cja_alu_if     alu ();

	cja_adder u_adder (.bus(alu));

	logic       isAdd;
	logic       isAddc;
	logic       isAndAcc;
	logic       useLatch;
	logic [7:0] srcByte;
	logic [7:0] andDirByte;
	logic       srcBit;
	logic       argCount;

	// ======================================================
	// Operand selection
	always_comb
	begin
		isAdd  = opcode inside {OP_ADD_DIR, OP_ADD_IMM, OP_ADD_IND,
			OP_ADD_IND + 8'h01} || opcode[7:3] == OP_ADD_REG[7:3];
		isAddc = opcode inside {OP_ADD_WITH_CARRY_DIR, OP_ADD_WITH_CARRY_IMM, OP_ADD_WITH_CARRY_IND,
			OP_ADD_WITH_CARRY_IND + 8'h01} || opcode[7:3] == OP_ADD_WITH_CARRY_REG[7:3];
		isAndAcc = opcode inside {OP_AND_DIR, OP_AND_IMM, OP_AND_IND,
			OP_AND_IND + 8'h01} || opcode[7:3] == OP_AND_REG[7:3];
		srcByte = dataRdByte;
		if (opcode[3])
			srcByte = regFile[opcode[2:0]];
		else if (opcode[2:0] == 3'h4)
			srcByte = arg1;
		// Ports read back their latch on read-modify-write
		useLatch   = arg1 >= PORT_LO;
		andDirByte = useLatch ? latchRdByte : dataRdByte;
		srcBit     = (opcode == OP_ANDC_NBIT) ? ~dataRdByte[0]
			: dataRdByte[0];
		argCount = opcode inside {OP_ADD_DIR, OP_ADD_IMM, OP_ADD_WITH_CARRY_DIR,
			OP_ADD_WITH_CARRY_IMM, OP_AND_DIR, OP_AND_IMM, OP_AND_DIRA,
			OP_AND_DIRI, OP_ANDC_BIT, OP_ANDC_NBIT}
			|| opcode[4:0] == OP_ABSOLUTE_CALL_LO || opcode[4:0] == OP_ABSOLUTE_JUMP_LO;
		alu.a   = acc;
		alu.b   = srcByte;
		alu.cin = isAddc & carry;
	end

	// ======================================================
	// Memory addressing
	assign progAddr = program_counter;

	// Registered so the read ports leave flops; a pointer
	// register written by the previous op has landed by now
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bitRd      <= 1'b0;
			dataRdAddr <= 8'h00;
		end
		else
		begin
			if (state == ST_FETCH)
				bitRd <= progData == OP_ANDC_BIT
					|| progData == OP_ANDC_NBIT;
			if (state == ST_ARG1 && opcode[2:1] == 2'b11 && !opcode[3])
				dataRdAddr <= regFile[{2'b00, opcode[0]}];
			else if (state == ST_ARG1 && argCount)
				dataRdAddr <= progData;
		end
	end

	// ======================================================
	// Sequencer, counter and stack
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state           <= ST_FETCH;
			opcode          <= 8'h00;
			arg1            <= 8'h00;
			retAddr         <= PC_RESET;
			program_counter <= PC_RESET;
			stack_pointer   <= SP_RESET;
			dataWr          <= 1'b0;
			dataWrAddr      <= 8'h00;
			dataWrByte      <= 8'h00;
			badOpcode       <= 1'b0;
		end
		else
		begin
			dataWr    <= 1'b0;
			badOpcode <= 1'b0;
			unique case (state)
				ST_FETCH:
				begin
					opcode          <= progData;
					program_counter <= program_counter + 16'h0001;
					state           <= ST_ARG1;
				end
				ST_ARG1:
				begin
					if (argCount)
					begin
						arg1            <= progData;
						program_counter <= program_counter + 16'h0001;
					end
					state <= (opcode == OP_AND_DIRI) ? ST_ARG2 : ST_EXEC;
				end
				ST_ARG2:
				begin
					// Immediate mask of the three-byte direct AND
					dataWrByte      <= progData;
					program_counter <= program_counter + 16'h0001;
					state           <= ST_EXEC;
				end
				ST_EXEC:
				begin
					state <= ST_FETCH;
					if (opcode[4:0] == OP_ABSOLUTE_CALL_LO)
					begin
						retAddr       <= program_counter;
						stack_pointer <= stack_pointer + 8'h01;
						dataWrAddr    <= stack_pointer + 8'h01;
						dataWrByte    <= program_counter[7:0];
						dataWr        <= 1'b1;
						program_counter <= {program_counter[15:11],
							opcode[7:5], arg1};
						state <= ST_PUSH;
					end
					else if (opcode[4:0] == OP_ABSOLUTE_JUMP_LO)
						program_counter <= {program_counter[15:11],
							opcode[7:5], arg1};
					else if (opcode == OP_AND_DIRA)
					begin
						dataWrAddr <= arg1;
						dataWrByte <= andDirByte & acc;
						dataWr     <= 1'b1;
					end
					else if (opcode == OP_AND_DIRI)
					begin
						dataWrAddr <= arg1;
						dataWrByte <= andDirByte & dataWrByte;
						dataWr     <= 1'b1;
					end
					else if (!(isAdd || isAddc || isAndAcc || bitRd))
						badOpcode <= 1'b1;
				end
				ST_PUSH:
				begin
					stack_pointer <= stack_pointer + 8'h01;
					dataWrAddr    <= stack_pointer + 8'h01;
					dataWrByte    <= retAddr[15:8];
					dataWr        <= 1'b1;
					state         <= ST_FETCH;
				end
			endcase
		end
	end

	// ======================================================
	// Accumulator and flags
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc                  <= 8'h00;
			carry                <= 1'b0;
			auxiliary_carry_flag <= 1'b0;
			overflow_flag        <= 1'b0;
		end
		else if (state == ST_EXEC)
		begin
			if (isAdd || isAddc)
			begin
				acc                  <= alu.sum;
				carry                <= alu.cy;
				auxiliary_carry_flag <= alu.ac;
				overflow_flag        <= alu.ov;
			end
			else if (isAndAcc)
				acc <= acc & srcByte;
			else if (bitRd && !srcBit)
				carry <= 1'b0;
		end
	end
endmodule : cja_core
`default_nettype wire

// ### sim/cja_core_monitor.sv
// Assertions on the ports of the execution core.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cja_core_monitor
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  dataWrAddr,
	input wire logic [7:0]  dataWrByte,
	input wire logic        dataWr,
	input wire logic        bitRd,
	input wire logic [7:0]  acc,
	input wire logic        carry,
	input wire logic        auxiliary_carry_flag,
	input wire logic        overflow_flag,
	input wire logic [7:0]  stack_pointer,
	input wire logic [15:0] program_counter,
	input wire logic        badOpcode
);
	logic [2:0] flags;
	assign flags = {carry, auxiliary_carry_flag, overflow_flag};
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========
	// Stack pushes
	a_sp_push: assert property ($changed(stack_pointer) |-> dataWr &&
		dataWrAddr == stack_pointer && stack_pointer == $past(stack_pointer) + 8'h01)
		else $error("stack write does not follow pointer");
	a_push_pair: assert property ($changed(stack_pointer) && !$past(dataWr)
		|=> dataWr && stack_pointer == $past(stack_pointer) + 8'h01)
		else $error("second push missing");
	a_call_page: assert property ($changed(stack_pointer) && !$past(dataWr)
		|=> program_counter[15:11] == dataWrByte[7:3])
		else $error("call left its 2K block");
	a_write_flags: assert property (dataWr |-> $stable(flags))
		else $error("flags moved on a write");
	// ==========
	// Bit AND into carry
	a_bit_no_write: assert property (bitRd |=> !dataWr)
		else $error("bit source written");
	a_bit_flags: assert property (bitRd |=> $stable(acc) &&
		$stable({auxiliary_carry_flag, overflow_flag}))
		else $error("bit AND changed other state");
	a_carry_no_set: assert property (bitRd |=> !$rose(carry))
		else $error("bit AND set carry");
	// Refused opcodes behave as no-ops
	a_bad_noop: assert property (badOpcode |-> $stable(acc) && $stable(flags)
		&& $stable(stack_pointer)) else $error("refused opcode changed state");
endmodule : cja_core_monitor
bind cja_core cja_core_monitor u_cja_core_monitor (.clk(clk), .nrst(nrst),
	.dataWrAddr(dataWrAddr), .dataWrByte(dataWrByte), .dataWr(dataWr),
	.bitRd(bitRd), .acc(acc), .carry(carry),
	.auxiliary_carry_flag(auxiliary_carry_flag), .overflow_flag(overflow_flag),
	.stack_pointer(stack_pointer), .program_counter(program_counter),
	.badOpcode(badOpcode));
`default_nettype wire

// ### sim/cja_mem_model.sv
// Program memory and internal data memory beside the core.
// Assumes reads answer in the same cycle; bench preloads arrays.
`timescale 1ns/1ps
`default_nettype none
module cja_mem_model
(
	input  wire logic        clk,
	input  wire logic [15:0] progAddr,
	output logic [7:0]       progData,
	input  wire logic [7:0]  dataRdAddr,
	output logic [7:0]       dataRdByte,
	output logic [7:0]       latchRdByte,
	input  wire logic        bitRd,
	input  wire logic [7:0]  dataWrAddr,
	input  wire logic [7:0]  dataWrByte,
	input  wire logic        dataWr,
	output logic [7:0]       regFile [8]
);
	logic [7:0] prog [4096];
	logic [7:0] mem [256];
	logic [7:0] bitByte;
	// ==========
	// Reads
	assign progData = prog[progAddr[11:0]];
	assign bitByte = dataRdAddr[7] ? {dataRdAddr[7:3], 3'h0}
		: {4'h2, dataRdAddr[6:3]};
	// Port pins read inverted on byte reads, so a latch slip cannot hide
	assign dataRdByte = bitRd ? {7'h00, mem[bitByte][dataRdAddr[2:0]]}
		: (dataRdAddr[7] ? ~mem[dataRdAddr] : mem[dataRdAddr]);
	assign latchRdByte = mem[dataRdAddr];
	always_comb
		for (int i = 0; i < 8; i++)
			regFile[i] = mem[i];
	// ==========
	// Writes; plain always since the bench also preloads
	always @(posedge clk)
		if (dataWr)
			mem[dataWrAddr] <= dataWrByte;
endmodule : cja_mem_model
`default_nettype wire

// ### sim/cpu_call_jump_add_and_exec_tb.sv
// Self-checking bench for the execution core.
// Assumes the memory model and bound monitor beside it.
`timescale 1ns/1ps
`default_nettype none
module cpu_call_jump_add_and_exec_tb;
	import cja_pkg::*;
	typedef struct {logic [7:0] p, q, op, arg, src; logic [1:0] kind;} cja_row_type;
	logic clk, nrst, bitRd, dataWr, carry, badOpcode;
	logic auxiliary_carry_flag, overflow_flag;
	logic [15:0] progAddr, program_counter;
	logic [7:0] progData, dataRdAddr, dataRdByte, latchRdByte, dataWrAddr;
	logic [7:0] dataWrByte, acc, stack_pointer;
	logic [7:0] regFile [8];
	logic [10:0] pre, exp;
	int errCount, cmpCount, cycles, badCount;
	cja_row_type rows [12] = '{
		'{8'hff, 8'hc4, 8'h2d, 8'h00, 8'haa, 2'h0}, '{8'h40, 8'h38, 8'h25, 8'h40, 8'h55, 2'h0},
		'{8'h01, 8'h00, 8'h26, 8'h00, 8'h0f, 2'h0}, '{8'h80, 8'h00, 8'h24, 8'h80, 8'h80, 2'h0},
		'{8'hff, 8'hc4, 8'h3d, 8'h00, 8'haa, 2'h1}, '{8'h80, 8'h80, 8'h35, 8'h40, 8'h55, 2'h1},
		'{8'hf0, 8'h20, 8'h37, 8'h00, 8'hf0, 2'h1}, '{8'h00, 8'h00, 8'h34, 8'h7f, 8'h7f, 2'h1},
		'{8'hff, 8'hc4, 8'h5d, 8'h00, 8'haa, 2'h2}, '{8'h0f, 8'hf8, 8'h55, 8'h40, 8'h55, 2'h2},
		'{8'hff, 8'h01, 8'h56, 8'h00, 8'h0f, 2'h2}, '{8'h3c, 8'h00, 8'h54, 8'hc3, 8'hc3, 2'h2}};
	logic [15:0] bits [4] = '{16'h8200, 16'h8201, 16'hb000, 16'hb001};
	cja_core u_cja_core (.*);
	cja_mem_model u_cja_mem_model (.*);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========
	// Helpers
	function automatic logic [10:0] add(input logic [7:0] a, b, input logic c);
		logic [8:0] s;
		logic [4:0] l;
		logic [7:0] m;
		s = a + b + c;
		l = a[3:0] + b[3:0] + c;
		m = a[6:0] + b[6:0] + c;
		return {s[8], l[4], s[8] ^ m[7], s[7:0]};
	endfunction : add
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		cmpCount++;
		if (got !== want)
		begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : check
	task automatic put(input int a, input logic [7:0] b [$]);
		foreach (b[i]) u_cja_mem_model.prog[a + i] = b[i];
	endtask : put
	task automatic start;
		@(posedge clk);
		#1 nrst = 1'b0;
		badCount = 0;
		foreach (u_cja_mem_model.mem[i]) u_cja_mem_model.mem[i] = 8'h00;
		u_cja_mem_model.mem[0] = 8'h30;
		u_cja_mem_model.mem[1] = 8'h31;
		u_cja_mem_model.mem[5] = 8'haa;
		u_cja_mem_model.mem[8'h30] = 8'h0f;
		u_cja_mem_model.mem[8'h31] = 8'hf0;
		u_cja_mem_model.mem[8'h40] = 8'h55;
		u_cja_mem_model.mem[8'h20] = 8'h01;
		u_cja_mem_model.mem[8'h90] = 8'hf5;
	endtask : start
	task automatic go;
		repeat (12) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (40) @(posedge clk);
		#1;
	endtask : go
	task automatic giveVerdict;
		$display("errors=%0d compares=%0d", errCount, cmpCount);
		if (errCount == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : giveVerdict
	// Refused-opcode pulses, seen mid-cycle so each counts once
	always @(negedge clk)
		if (badOpcode === 1'b1)
			badCount++;
	// Hang guard, far above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errCount++;
			giveVerdict();
		end
	end
	// ==========
	// Main sequence
	initial
	begin
		nrst = 1'b0;
		foreach (rows[i])
		begin
			start();
			put(0, '{8'h24, rows[i].p, 8'h24, rows[i].q, rows[i].op, rows[i].arg, 8'h01, 8'h06});
			go();
			pre = add(rows[i].p, rows[i].q, 1'b0);
			exp = rows[i].kind == 2'h2 ? {pre[10:8], pre[7:0] & rows[i].src}
				: add(pre[7:0], rows[i].src, rows[i].kind[0] & pre[10]);
			check({5'h00, carry, auxiliary_carry_flag, overflow_flag, acc}, {5'h00, exp});
			check(16'(badCount), {15'h0000, rows[i].op[3] || rows[i].op[2:1] == 2'b11});
			// Two more edges end the jump loop's execute cycle
			repeat (2) @(posedge clk);
			#1;
			check(program_counter, 16'h0006);
		end
		start();
		put(0, '{8'h21, 8'h23});
		put(12'h123, '{8'h71, 8'h45});
		put(12'h345, '{8'h61, 8'h45});
		go();
		check(program_counter, 16'h0345);
		check({8'h00, stack_pointer}, 16'h0009);
		check({u_cja_mem_model.mem[9], u_cja_mem_model.mem[8]}, 16'h0125);
		check({13'h0000, carry, auxiliary_carry_flag, overflow_flag}, 16'h0000);
		start();
		put(0, '{8'h24, 8'h3c, 8'h52, 8'h90, 8'h53, 8'h40, 8'h0f, 8'h01, 8'h07});
		go();
		check({u_cja_mem_model.mem[8'h90], u_cja_mem_model.mem[8'h40]}, 16'h3405);
		check({8'h00, acc}, 16'h003c);
		foreach (bits[i])
		begin
			start();
			put(0, '{8'h24, 8'hff, 8'h24, 8'h01, bits[i][15:8], bits[i][7:0], 8'h01, 8'h06});
			go();
			check({13'h0000, carry, auxiliary_carry_flag, overflow_flag}, {13'h0000, i == 0 || i == 3, 2'b10});
			check({8'h00, u_cja_mem_model.mem[8'h20]}, 16'h0001);
		end
		giveVerdict();
	end
endmodule : cpu_call_jump_add_and_exec_tb
`default_nettype wire
